/* logic/pccd_map.svh */
`ifndef PCCD_MAP_SVH
`define PCCD_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define PCCD_IDX_PH0 9'h190
`define PCCD_IDX_CTL0 9'h191
`define PCCD_IDX_RT0 9'h192
`define PCCD_IDX_PH1 9'h196
`define PCCD_IDX_CTL1 9'h197
`define PCCD_IDX_INSEL 9'h1E1
`define PCCD_IDX_STAT 9'h1E2

// reset values
`define PCCD_RST_PH0 8'h00
`define PCCD_RST_CTL0 8'h80
`define PCCD_RST_RT0 8'h00
`define PCCD_RST_PH1 8'h00
`define PCCD_RST_CTL1 8'h00
`define PCCD_RST_INSEL 2'h2

// phase length register fields
`define PCCD_LOW_HI 7
`define PCCD_LOW_LO 4
`define PCCD_HIGH_HI 3
`define PCCD_HIGH_LO 0

// control register fields
`define PCCD_CTL_BYPASS 7
`define PCCD_CTL_NOSYNC 6
`define PCCD_CTL_FORCE 5
`define PCCD_CTL_START 4
`define PCCD_PHASE_HI 3
`define PCCD_PHASE_LO 0

// routing register fields
`define PCCD_RT_DIRECT 1
`define PCCD_RT_DUTY_CORRECTION_DISABLE 0

// input select encodings
`define PCCD_SEL_EXT 2'h0
`define PCCD_SEL_NONE 2'h1
`define PCCD_SEL_OSC 2'h2

`endif

/* logic/pccd_pkg.sv */
package pccd_pkg;

  // settings of one channel divider
  typedef struct packed {
    logic [3:0] lowCyc;
    logic [3:0] highCyc;
    logic bypass;
    logic nosync;
    logic forceHigh;
    logic startHigh;
    logic [3:0] phase;
  } pccd_cfg_t;

  // divider sequencing, gray along hold -> delay -> run
  typedef enum logic [1:0] {
    S_HOLD = 2'b00,
    S_DELAY = 2'b01,
    S_RUN = 2'b11
  } pccd_state_t;

endpackage

/* logic/pccd_chan_div.sv */
`timescale 1ns/1ps
module pccd_chan_div
  import pccd_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire pccd_cfg_t cfg, // divider settings
  input wire logic tick, // one pulse per divider input clock rising edge
  input wire logic inLevel, // divider input clock level
  input wire logic syncActive, // chip-level sync asserted
  output logic divOut, // divider output level
  output logic running // divider is counting
);

  pccd_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic lvl, next_lvl;
  logic next_out;

  // length of the phase spent at the given level
  function automatic logic [3:0] phaseLen(input pccd_cfg_t c, input logic level);
    phaseLen = level ? c.highCyc : c.lowCyc;
  endfunction

  // divider sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_lvl = lvl;
    next_out = divOut;
    if (cfg.bypass) begin
      next_state = S_HOLD;
      next_cnt = 4'h0;
      next_lvl = cfg.startHigh;
      next_out = inLevel;
    end else if (cfg.nosync && cfg.forceHigh) begin
      next_state = S_HOLD;
      next_cnt = 4'h0;
      next_lvl = cfg.startHigh;
      next_out = 1'b1;
    end else if (!cfg.nosync && syncActive) begin
      next_state = S_HOLD;
      next_cnt = 4'h0;
      next_lvl = cfg.startHigh;
      next_out = cfg.startHigh;
    end else begin
      unique case (state)
        S_HOLD: begin
          next_lvl = cfg.startHigh;
          next_out = cfg.startHigh;
          if (cfg.phase == 4'h0) begin
            next_state = S_RUN;
            next_cnt = phaseLen(cfg, cfg.startHigh);
          end else begin
            next_state = S_DELAY;
            next_cnt = cfg.phase - 4'h1;
          end
        end
        S_DELAY: begin
          next_out = lvl;
          if (tick) begin
            if (cnt == 4'h0) begin
              next_state = S_RUN;
              next_cnt = phaseLen(cfg, lvl);
            end else begin
              next_cnt = cnt - 4'h1;
            end
          end
        end
        S_RUN: begin
          next_out = lvl;
          if (tick) begin
            if (cnt == 4'h0) begin
              next_lvl = !lvl;
              next_cnt = phaseLen(cfg, !lvl);
            end else begin
              next_cnt = cnt - 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_HOLD;
      cnt <= 4'h0;
      lvl <= 1'b0;
      divOut <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lvl <= next_lvl;
      divOut <= next_out;
    end
  end

  assign running = (state == S_RUN);

  // helper counters watched by the checks below
  logic [4:0] phaseTicks;
  logic [4:0] delayTicks;
  logic dirty;
  pccd_cfg_t cfgQ;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phaseTicks <= 5'h00;
      delayTicks <= 5'h00;
      dirty <= 1'b0;
      cfgQ <= '0;
    end else begin
      cfgQ <= cfg;
      if (state != S_RUN || lvl != next_lvl) begin
        phaseTicks <= 5'h00;
        dirty <= (cfg != cfgQ);
      end else begin
        phaseTicks <= phaseTicks + {4'h0, tick};
        dirty <= dirty | (cfg != cfgQ);
      end
      if (state != S_DELAY) begin
        delayTicks <= 5'h00;
      end else begin
        delayTicks <= delayTicks + {4'h0, tick};
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence heldBySync;
    (!cfg.bypass && !cfg.nosync && syncActive) [*2];
  endsequence

  sequence heldByForce;
    (!cfg.bypass && cfg.nosync && cfg.forceHigh) [*2];
  endsequence

  lowPhase_len_a: assert property (
    ($rose(lvl) && state == S_RUN && $past(state) == S_RUN && !$past(dirty) && $past(cfg) == $past(cfgQ))
    |-> $past(phaseTicks) == {1'b0, $past(cfg.lowCyc)})
    else $error("low phase length wrong");
  highPhase_len_a: assert property (
    ($fell(lvl) && state == S_RUN && $past(state) == S_RUN && !$past(dirty) && $past(cfg) == $past(cfgQ))
    |-> $past(phaseTicks) == {1'b0, $past(cfg.highCyc)})
    else $error("high phase length wrong");
  bypass_follow_a: assert property (
    (cfg.bypass && $past(cfg.bypass)) |-> (divOut == $past(inLevel) && state == S_HOLD))
    else $error("bypass does not pass input clock");
  sync_hold_a: assert property (
    heldBySync |=> (state == S_HOLD && divOut == $past(cfg.startHigh)))
    else $error("divider not held by sync");
  force_high_a: assert property (
    heldByForce |=> divOut)
    else $error("forced output not high");
  start_level_a: assert property (
    (state == S_RUN && $past(state) != S_RUN && $past(cfg) == cfg) |-> lvl == cfg.startHigh)
    else $error("wrong start level");
  phase_delay_a: assert property (
    (state == S_RUN && $past(state) == S_DELAY && $past(cfg) == $past(cfgQ) && $stable(cfg.phase))
    |-> $past(delayTicks) == {1'b0, cfg.phase} - 5'h01)
    else $error("phase offset delay wrong");

endmodule

/* logic/pccd_top.sv */
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// - low phase lasts low-cycles field plus one input clock cycles
// - high phase lasts high-cycles field plus one input clock cycles
// - bypass bit stops counting and passes the input clock straight through
// - after reset divider 0 is bypassed and divider 1 divides
// - a divider follows chip sync unless its sync-ignore bit is set
// - with sync-ignore set, force bit drives a static level; software sets both
// - start-level bit picks the level the divided clock begins with
// - phase offset delays the divider start by that many input clocks
// - direct route sends oscillator or external clock to pair 0 outputs
// - duty correction is on while its disable bit is clear
`include "pccd_map.svh"
module pccd_top
  import pccd_pkg::*;
(
  input wire logic mclk, // 100 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [10:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic oscPin, // internal oscillator clock level
  input wire logic extPin, // external clock input level
  input wire logic syncPin_n, // chip-level sync, active low
  output logic pair0OutA, // first output of pair 0
  output logic pair0OutB, // second output of pair 0
  output logic pair1OutA, // first output of pair 1
  output logic pair1OutB, // second output of pair 1
  output logic dccEnable0 // duty correction enable to pair 0 driver
);

  // two-flop synchronisers for the three pins
  logic [2:0] pinRaw;
  logic [2:0] syncA;
  logic [2:0] syncB;
  assign pinRaw = {!syncPin_n, extPin, oscPin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else begin
          syncA[gi] <= pinRaw[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  logic oscLvl;
  logic extLvl;
  logic syncActive;
  assign oscLvl = syncB[0];
  assign extLvl = syncB[1];
  assign syncActive = syncB[2];

  // configuration registers
  logic [7:0] ph0, next_ph0;
  logic [7:0] ctl0, next_ctl0;
  logic [7:0] rt0, next_rt0;
  logic [7:0] ph1, next_ph1;
  logic [7:0] ctl1, next_ctl1;
  logic [1:0] insel, next_insel;
  logic [31:0] next_datO;
  logic next_ack;

  logic wbHit;
  logic wbWrite;
  logic [8:0] wbIdx;
  logic [7:0] wrByte;
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbHit && wb_we_i && wb_sel_i[0];
  assign wbIdx = wb_adr_i[10:2];
  assign wrByte = wb_dat_i[7:0];

  logic div0Out;
  logic div1Out;
  logic div0Run;
  logic div1Run;

  // register read decode; unmapped indices read as zero
  function automatic logic [7:0] readReg(input logic [8:0] idx);
    unique case (idx)
      `PCCD_IDX_PH0: readReg = ph0;
      `PCCD_IDX_CTL0: readReg = ctl0;
      `PCCD_IDX_RT0: readReg = {6'h00, rt0[`PCCD_RT_DIRECT:`PCCD_RT_DUTY_CORRECTION_DISABLE]};
      `PCCD_IDX_PH1: readReg = ph1;
      `PCCD_IDX_CTL1: readReg = ctl1;
      `PCCD_IDX_INSEL: readReg = {6'h00, insel};
      `PCCD_IDX_STAT: readReg = {4'h0, div1Run, div0Run, pair1OutA, pair0OutA};
      default: readReg = 8'h00;
    endcase
  endfunction

  // decode of a phase length byte and a control byte into divider settings
  function automatic pccd_cfg_t makeCfg(input logic [7:0] ph, input logic [7:0] ctl);
    makeCfg.lowCyc = ph[`PCCD_LOW_HI:`PCCD_LOW_LO];
    makeCfg.highCyc = ph[`PCCD_HIGH_HI:`PCCD_HIGH_LO];
    makeCfg.bypass = ctl[`PCCD_CTL_BYPASS];
    makeCfg.nosync = ctl[`PCCD_CTL_NOSYNC];
    makeCfg.forceHigh = ctl[`PCCD_CTL_FORCE];
    makeCfg.startHigh = ctl[`PCCD_CTL_START];
    makeCfg.phase = ctl[`PCCD_PHASE_HI:`PCCD_PHASE_LO];
  endfunction

  // register writes and bus answer
  always_comb begin
    next_ph0 = ph0;
    next_ctl0 = ctl0;
    next_rt0 = rt0;
    next_ph1 = ph1;
    next_ctl1 = ctl1;
    next_insel = insel;
    next_ack = wbHit;
    next_datO = 32'h0000_0000;
    if (wbHit && !wb_we_i) begin
      next_datO = {24'h00_0000, readReg(wbIdx)};
    end
    if (wbWrite) begin
      unique case (wbIdx)
        `PCCD_IDX_PH0: next_ph0 = wrByte;
        `PCCD_IDX_CTL0: next_ctl0 = wrByte;
        `PCCD_IDX_RT0: next_rt0 = {6'h00, wrByte[`PCCD_RT_DIRECT:`PCCD_RT_DUTY_CORRECTION_DISABLE]};
        `PCCD_IDX_PH1: next_ph1 = wrByte;
        `PCCD_IDX_CTL1: next_ctl1 = wrByte;
        `PCCD_IDX_INSEL: next_insel = wrByte[1:0];
        default: next_ack = wbHit;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph0 <= `PCCD_RST_PH0;
      ctl0 <= `PCCD_RST_CTL0;
      rt0 <= `PCCD_RST_RT0;
      ph1 <= `PCCD_RST_PH1;
      ctl1 <= `PCCD_RST_CTL1;
      insel <= `PCCD_RST_INSEL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ph0 <= next_ph0;
      ctl0 <= next_ctl0;
      rt0 <= next_rt0;
      ph1 <= next_ph1;
      ctl1 <= next_ctl1;
      insel <= next_insel;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_datO;
    end
  end

  // divider input clock and its rising-edge tick
  logic inLevel;
  logic inPrev;
  logic next_inPrev;
  logic tick;
  assign inLevel = (insel == `PCCD_SEL_EXT) ? extLvl : oscLvl;
  assign tick = inLevel && !inPrev;

  always_comb begin
    next_inPrev = inLevel;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inPrev <= 1'b0;
    end else begin
      inPrev <= next_inPrev;
    end
  end

  pccd_cfg_t cfg0;
  pccd_cfg_t cfg1;
  assign cfg0 = makeCfg(ph0, ctl0);
  assign cfg1 = makeCfg(ph1, ctl1);

  // channel divider feeding pair 0
  pccd_chan_div u_div0 (
    .mclk(mclk),
    .rst_n(rst_n),
    .cfg(cfg0),
    .tick(tick),
    .inLevel(inLevel),
    .syncActive(syncActive),
    .divOut(div0Out),
    .running(div0Run)
  );

  // channel divider feeding pair 1
  pccd_chan_div u_div1 (
    .mclk(mclk),
    .rst_n(rst_n),
    .cfg(cfg1),
    .tick(tick),
    .inLevel(inLevel),
    .syncActive(syncActive),
    .divOut(div1Out),
    .running(div1Run)
  );

  // output routing and duty correction control
  logic next_p0;
  logic next_p1;
  logic next_dcc;
  always_comb begin
    next_p0 = div0Out;
    if (rt0[`PCCD_RT_DIRECT]) begin
      if (insel == `PCCD_SEL_OSC) begin
        next_p0 = oscLvl;
      end else if (insel == `PCCD_SEL_EXT) begin
        next_p0 = extLvl;
      end
    end
    next_p1 = div1Out;
    next_dcc = !rt0[`PCCD_RT_DUTY_CORRECTION_DISABLE];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pair0OutA <= 1'b0;
      pair0OutB <= 1'b0;
      pair1OutA <= 1'b0;
      pair1OutB <= 1'b0;
      dccEnable0 <= 1'b0;
    end else begin
      pair0OutA <= next_p0;
      pair0OutB <= next_p0;
      pair1OutA <= next_p1;
      pair1OutB <= next_p1;
      dccEnable0 <= next_dcc;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  reset_defaults_a: assert property (
    ($past(!rst_n) && !$past(wbWrite)) |-> (ctl0[`PCCD_CTL_BYPASS] && !ctl1[`PCCD_CTL_BYPASS]))
    else $error("divider defaults wrong after reset");
  route_osc_a: assert property (
    (rt0[`PCCD_RT_DIRECT] && insel == `PCCD_SEL_OSC) |=> (pair0OutA == $past(oscLvl) && pair0OutB == pair0OutA))
    else $error("oscillator not routed to pair 0");
  route_ext_a: assert property (
    (rt0[`PCCD_RT_DIRECT] && insel == `PCCD_SEL_EXT) |=> pair0OutA == $past(extLvl))
    else $error("external clock not routed to pair 0");
  route_div_a: assert property (
    (!rt0[`PCCD_RT_DIRECT] || insel == `PCCD_SEL_NONE) |=> pair0OutA == $past(div0Out))
    else $error("pair 0 not fed by divider");
  dcc_enable_a: assert property (
    $changed(rt0[`PCCD_RT_DUTY_CORRECTION_DISABLE]) |=> dccEnable0 == !$past(rt0[`PCCD_RT_DUTY_CORRECTION_DISABLE]))
    else $error("duty correction enable wrong");
  // both outputs of a pair always carry the same level
  pair_copies_a: assert property (
    (pair0OutB == pair0OutA) && (pair1OutB == pair1OutA))
    else $error("pair outputs differ");
  bus_ack_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

endmodule

/* verification/pccd_top_bench.sv */
`timescale 1ns/1ps
`include "pccd_map.svh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module pccd_top_bench
  import pccd_pkg::*;
;
  localparam int LIMIT = 60000;
  logic mclk;
  logic rst_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [10:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic oscPin;
  logic extPin;
  logic syncPin_n;
  logic pair0OutA;
  logic pair0OutB;
  logic pair1OutA;
  logic pair1OutB;
  logic dccEnable0;
  int errors = 0;
  int checks = 0;
  int ckCnt = 0;

  pccd_top dut_u (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .oscPin(oscPin), .extPin(extPin), .syncPin_n(syncPin_n),
    .pair0OutA(pair0OutA), .pair0OutB(pair0OutB), .pair1OutA(pair1OutA), .pair1OutB(pair1OutB),
    .dccEnable0(dccEnable0)
  );

  // system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // oscillator runs at mclk/8, external clock at mclk/12; run length watchdog
  always @(posedge mclk) begin
    ckCnt <= ckCnt + 1;
    if (ckCnt % 4 == 3) oscPin <= ~oscPin;
    if (ckCnt % 6 == 5) extPin <= ~extPin;
    if (ckCnt == LIMIT) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // expected phase length in mclk cycles for a field value
  function automatic int phaseLen(input logic [3:0] f, input int tick);
    return (int'(f) + 1) * tick;
  endfunction

  function automatic logic outSel(input int which);
    return which ? pair1OutA : pair0OutA;
  endfunction

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wbAccess(input logic [8:0] idx, input logic we, input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h00_0000, wd};
    wb_sel_i <= 4'hF;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20) errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wbWrite(input logic [8:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    wbAccess(idx, 1'b1, wd, rd);
  endtask

  // skips the settling period, then counts one high and one low phase
  task automatic measure(input int which, output int hi, output int lo);
    hi = 0;
    lo = 0;
    @(negedge mclk);
    repeat (2) begin
      while (outSel(which) !== 1'b1) @(negedge mclk);
      while (outSel(which) !== 1'b0) @(negedge mclk);
    end
    while (outSel(which) !== 1'b1) @(negedge mclk);
    while (outSel(which) === 1'b1) begin
      hi++;
      @(negedge mclk);
    end
    while (outSel(which) === 1'b0) begin
      lo++;
      @(negedge mclk);
    end
  endtask

  // changes the sync pin on an oscillator period boundary
  task automatic syncSet(input logic v);
    @(posedge mclk);
    while (ckCnt % 8 != 0) @(posedge mclk);
    syncPin_n <= v;
  endtask

  logic [8:0] rstIdx [6] = '{`PCCD_IDX_PH0, `PCCD_IDX_CTL0, `PCCD_IDX_RT0, `PCCD_IDX_PH1, `PCCD_IDX_CTL1,
    `PCCD_IDX_INSEL};
  logic [7:0] rstVal [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h02};
  logic [7:0] holdCtl [3] = '{8'h00, 8'h10, 8'h60};
  logic holdExp [3] = '{1'b0, 1'b1, 1'b1};
  logic [7:0] selCode [3] = '{8'h00, 8'h02, 8'h01};
  int selLen [3] = '{6, 4, 16};
  int phList [3] = '{0, 3, 15};

  // main sequence
  initial begin
    logic [31:0] rd;
    logic [7:0] ph;
    int hi;
    int lo;
    int t;
    int t0;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 11'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    oscPin = 1'b0;
    extPin = 1'b0;
    syncPin_n = 1'b1;
    t0 = 0;
    void'($urandom(8638));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values of every register
    for (int i = 0; i < 6; i++) begin
      wbAccess(rstIdx[i], 1'b0, 8'h00, rd);
      `CHECK(rd, {24'h00_0000, rstVal[i]})
    end
    `CHECK(dccEnable0, 1'b1)
    wbAccess(`PCCD_IDX_STAT, 1'b0, 8'h00, rd);
    `CHECK(rd[3:2], 2'b10)
    wbWrite(9'h193, 8'hA5);
    wbAccess(9'h193, 1'b0, 8'h00, rd);
    `CHECK(rd, 32'h0000_0000)
    // divider 0 bypassed follows the oscillator, divider 1 divides by two
    measure(0, hi, lo);
    `CHECK(hi + lo, 8)
    measure(1, hi, lo);
    `CHECK(hi + lo, 16)
    // phase lengths on both dividers: corners then random values
    wbWrite(`PCCD_IDX_CTL0, 8'h00);
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 5; k++) begin
        ph = (k == 0) ? 8'hFF : (k == 1) ? 8'hF0 : 8'($urandom);
        wbWrite(d ? `PCCD_IDX_PH1 : `PCCD_IDX_PH0, ph);
        wbAccess(d ? `PCCD_IDX_PH1 : `PCCD_IDX_PH0, 1'b0, 8'h00, rd);
        `CHECK(rd, {24'h00_0000, ph})
        measure(d, hi, lo);
        `CHECK(hi, phaseLen(ph[3:0], 8))
        `CHECK(lo, phaseLen(ph[7:4], 8))
        `CHECK(hi + lo, phaseLen(ph[7:4], 8) + phaseLen(ph[3:0], 8))
      end
    end
    // bypass passes the input clock unchanged
    wbWrite(`PCCD_IDX_CTL1, 8'h80);
    measure(1, hi, lo);
    `CHECK(hi, 4)
    `CHECK(lo, 4)
    // levels held while sync is asserted
    wbWrite(`PCCD_IDX_PH1, 8'h00);
    syncSet(1'b0);
    for (int i = 0; i < 3; i++) begin
      wbWrite(`PCCD_IDX_CTL1, holdCtl[i]);
      repeat (40) @(negedge mclk);
      repeat (24) begin
        @(negedge mclk);
        `CHECK(pair1OutA, holdExp[i])
        `CHECK(pair1OutB, holdExp[i])
      end
    end
    wbWrite(`PCCD_IDX_CTL1, 8'h40);
    measure(1, hi, lo);
    `CHECK(hi + lo, 16)
    // phase offset delays the first rise after sync release
    for (int i = 0; i < 3; i++) begin
      wbWrite(`PCCD_IDX_CTL1, 8'(phList[i]));
      syncSet(1'b0);
      repeat (30) @(negedge mclk);
      syncSet(1'b1);
      t = 0;
      @(negedge mclk);
      while (pair1OutA !== 1'b1) begin
        t++;
        @(negedge mclk);
      end
      if (i == 0) t0 = t;
      else `CHECK(t - t0, phList[i] * 8)
    end
    // direct route of pair 0 for each input select code
    wbWrite(`PCCD_IDX_PH0, 8'h11);
    wbWrite(`PCCD_IDX_RT0, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wbWrite(`PCCD_IDX_INSEL, selCode[i]);
      measure(0, hi, lo);
      `CHECK(hi, selLen[i])
      `CHECK(lo, selLen[i])
      `CHECK(pair0OutB, pair0OutA)
    end
    // duty correction enable follows its disable bit
    wbWrite(`PCCD_IDX_RT0, 8'h01);
    repeat (4) @(negedge mclk);
    `CHECK(dccEnable0, 1'b0)
    wbWrite(`PCCD_IDX_RT0, 8'h00);
    repeat (4) @(negedge mclk);
    `CHECK(dccEnable0, 1'b1)
    final_report();
  end
endmodule
